// file: logic/embi_defs.svh
`ifndef EMBI_DEFS_SVH
`define EMBI_DEFS_SVH

`define EMBI_ADDR_W      24
`define EMBI_DATA_W      32
`define EMBI_BE_W        4
`define EMBI_SYNC_N      4
`define EMBI_SYNC_READY  0
`define EMBI_SYNC_HOLD   1
`define EMBI_SYNC_SHZ    2
`define EMBI_SYNC_STRAP  3
`define EMBI_BE_IDLE     4'hF
`define EMBI_BE_WORD     4'h0
`define EMBI_BE_LO_HALF  4'hC
`define EMBI_BE_HI_HALF  4'h3
`define EMBI_BYTE_ONE    4'h1
`define EMBI_ADDR_RST    24'h000000
`define EMBI_DATA_RST    32'h00000000
// cycles a fresh beat waits before trusting synchronised ready
`define EMBI_RDY_BLANK   3'h5

`endif

// file: logic/embi_pkg.sv
package embi_pkg;

  typedef enum logic [1:0] {
    EMBI_W8  = 2'h0,
    EMBI_W16 = 2'h1,
    EMBI_W32 = 2'h2
  } embi_width_t;

  typedef enum logic [1:0] {
    EMBI_SZ_BYTE = 2'h0,
    EMBI_SZ_HALF = 2'h1,
    EMBI_SZ_WORD = 2'h2
  } embi_size_t;

  typedef enum logic [1:0] {
    EMBI_SP_BANK0 = 2'h0,
    EMBI_SP_BANK1 = 2'h1,
    EMBI_SP_IO    = 2'h2
  } embi_space_t;

  typedef enum logic [1:0] {
    EMBI_ST_IDLE   = 2'h0,
    EMBI_ST_ACCESS = 2'h1,
    EMBI_ST_HOLD   = 2'h2
  } embi_state_t;

endpackage : embi_pkg

// file: logic/embi_sync_if.sv
`include "embi_defs.svh"

interface embi_sync_if;
  logic [`EMBI_SYNC_N-1:0] raw;
  logic [`EMBI_SYNC_N-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : embi_sync_if

// file: logic/embi_pin_sync.sv
`include "embi_defs.svh"

module embi_pin_sync
  import embi_pkg::*;
(
  input  wire logic  clock_i,
  embi_sync_if.sync  pins
);

  genvar g;
  generate
    for (g = 0; g < `EMBI_SYNC_N; g = g + 1)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic clean_reg;
      logic clean_next;

      // a change counts once stages two and three agree
      always_comb
      begin
        clean_next = (s2_reg == s3_reg) ? s3_reg : clean_reg;
      end

      always_ff @(posedge clock_i)
      begin
        s1_reg    <= pins.raw[g];
        s2_reg    <= s1_reg;
        s3_reg    <= s2_reg;
        clean_reg <= clean_next;
      end

      assign pins.clean[g] = clean_reg;
    end
  endgenerate

endmodule : embi_pin_sync

// file: logic/embi_bus_ctrl.sv
`include "embi_defs.svh"

module embi_bus_ctrl
  import embi_pkg::*;
(
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic                    req_prog_i,
  input  wire embi_space_t             req_space_i,
  input  wire embi_size_t              req_size_i,
  input  wire logic [`EMBI_ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]              req_off_i,
  input  wire logic [`EMBI_DATA_W-1:0] req_wdata_i,
  output logic                         req_ready_o,
  output logic                         rsp_valid_o,
  output logic [`EMBI_DATA_W-1:0]      rsp_rdata_o,
  input  wire logic                    cfg_wr_i,
  input  wire logic                    cfg_bank_i,
  input  wire embi_width_t             cfg_width_i,
  input  wire logic                    cfg_hold_ignore_i,
  output logic [`EMBI_ADDR_W-1:0]      ext_addr_lines_o,
  output logic                         ext_addr_oe_o,
  input  wire logic [`EMBI_DATA_W-1:0] ext_data_lines_i,
  output logic [`EMBI_DATA_W-1:0]      ext_data_lines_o,
  output logic                         ext_data_oe_o,
  output logic                         ext_rw_o,
  output logic                         ext_rw_oe_o,
  output logic                         periph_io_strobe_n_o,
  output logic                         bank0_be3_addr1_n_o,
  output logic                         bank0_be2_addr2_n_o,
  output logic                         bank0_be1_n_o,
  output logic                         bank0_be0_n_o,
  output logic                         bank1_be3_addr1_n_o,
  output logic                         bank1_be2_addr2_n_o,
  output logic                         bank1_be1_n_o,
  output logic                         bank1_be0_n_o,
  output logic                         strobe_oe_o,
  input  wire logic                    ext_ready_n_i,
  input  wire logic                    hold_req_n_i,
  output logic                         bus_release_ack_n_o,
  input  wire logic                    shutdown_float_input_n_i,
  input  wire logic                    prog_fetch_width_strap_i
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  embi_sync_if sync_bus ();

  assign sync_bus.raw[`EMBI_SYNC_READY] = ext_ready_n_i;
  assign sync_bus.raw[`EMBI_SYNC_HOLD]  = hold_req_n_i;
  assign sync_bus.raw[`EMBI_SYNC_SHZ]   = shutdown_float_input_n_i;
  assign sync_bus.raw[`EMBI_SYNC_STRAP] = prog_fetch_width_strap_i;

  embi_pin_sync u_sync (
    .clock_i (clock_i),
    .pins    (sync_bus.sync)
  );

  logic ready_now;
  logic hold_req_now;
  logic shz_now;
  logic strap_now;

  assign ready_now    = ~sync_bus.clean[`EMBI_SYNC_READY];
  assign hold_req_now = ~sync_bus.clean[`EMBI_SYNC_HOLD];
  assign shz_now      = ~sync_bus.clean[`EMBI_SYNC_SHZ];
  assign strap_now    = sync_bus.clean[`EMBI_SYNC_STRAP];

  ////////////////////////////////////////////////////////////////////////////
  // state

  embi_state_t              st_reg,     st_next;
  embi_width_t              w0_reg,     w0_next;
  embi_width_t              w1_reg,     w1_next;
  logic                     ign_reg,    ign_next;
  logic                     wr_reg,     wr_next;
  embi_space_t              sp_reg,     sp_next;
  embi_size_t               sz_reg,     sz_next;
  embi_width_t              ow_reg,     ow_next;
  logic [`EMBI_ADDR_W-1:0]  oa_reg,     oa_next;
  logic [1:0]               off_reg,    off_next;
  logic [1:0]               beat_reg,   beat_next;
  logic [1:0]               last_reg,   last_next;
  logic [2:0]               blk_reg,    blk_next;
  logic [`EMBI_DATA_W-1:0]  wd_reg,     wd_next;
  logic [`EMBI_DATA_W-1:0]  rd_reg,     rd_next;
  logic                     rdy_reg,    rdy_next;
  logic                     rsp_reg,    rsp_next;
  logic [`EMBI_ADDR_W-1:0]  addr_reg,   addr_next;
  logic                     aoe_reg,    aoe_next;
  logic [`EMBI_DATA_W-1:0]  dout_reg,   dout_next;
  logic                     doe_reg,    doe_next;
  logic                     rw_reg,     rw_next;
  logic                     rwoe_reg,   rwoe_next;
  logic                     io_reg,     io_next;
  logic [`EMBI_BE_W-1:0]    b0_reg,     b0_next;
  logic [`EMBI_BE_W-1:0]    b1_reg,     b1_next;
  logic                     soe_reg,    soe_next;
  logic                     ack_reg,    ack_next;

  logic                     hold_act;
  logic                     float_bus;
  logic [1:0]               lane;
  logic [`EMBI_BE_W-1:0]    be;
  embi_width_t              req_w;
  logic [1:0]               req_last;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    hold_act = hold_req_now & ~ign_reg;
    st_next   = st_reg;
    w0_next   = w0_reg;
    w1_next   = w1_reg;
    ign_next  = ign_reg;
    wr_next   = wr_reg;
    sp_next   = sp_reg;
    sz_next   = sz_reg;
    ow_next   = ow_reg;
    oa_next   = oa_reg;
    off_next  = off_reg;
    beat_next = beat_reg;
    last_next = last_reg;
    blk_next  = blk_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    rsp_next  = 1'b0;
    lane      = 2'h0;
    be        = `EMBI_BE_IDLE;

    // width of the request's bank, 32 bits for I/O space; program fetch uses this same width
    case (req_space_i)
      EMBI_SP_BANK0: req_w = w0_reg;
      EMBI_SP_BANK1: req_w = w1_reg;
      default:       req_w = EMBI_W32;
    endcase
    case (req_w)
      EMBI_W8:  req_last = (req_size_i == EMBI_SZ_WORD) ? 2'h3 : ((req_size_i == EMBI_SZ_HALF) ? 2'h1 : 2'h0);
      EMBI_W16: req_last = (req_size_i == EMBI_SZ_WORD) ? 2'h1 : 2'h0;
      default:  req_last = 2'h0;
    endcase

    if (cfg_wr_i)
    begin
      if (cfg_bank_i)
        w1_next = cfg_width_i;
      else
      begin
        w0_next  = cfg_width_i;
        ign_next = cfg_hold_ignore_i;
      end
    end

    case (st_reg)
      EMBI_ST_IDLE:
      begin
        if (req_valid_i && rdy_reg)
        begin
          st_next   = EMBI_ST_ACCESS;
          wr_next   = req_write_i & ~req_prog_i;
          sp_next   = req_space_i;
          sz_next   = req_prog_i ? EMBI_SZ_WORD : req_size_i;
          ow_next   = req_w;
          oa_next   = req_addr_i;
          off_next  = req_prog_i ? 2'h0 : req_off_i;
          beat_next = 2'h0;
          blk_next  = `EMBI_RDY_BLANK;
          last_next = req_prog_i ? ((req_w == EMBI_W32) ? 2'h0 : 2'h1) : req_last;
          wd_next   = req_wdata_i;
          rd_next   = `EMBI_DATA_RST;
        end
        else if (hold_act)
          st_next = EMBI_ST_HOLD;
      end
      EMBI_ST_ACCESS:
      begin
        // synchronised ready still shows the previous beat
        if (blk_reg != 3'h0)
          blk_next = blk_reg - 3'h1;
        else if (ready_now)
        begin
          case (ow_reg)
            EMBI_W8:  rd_next[{off_reg + beat_reg, 3'h0} +: 8] = ext_data_lines_i[7:0];
            EMBI_W16: rd_next[{off_reg[1] ^ beat_reg[0], 4'h0} +: 16] = ext_data_lines_i[15:0];
            default:  rd_next = ext_data_lines_i;
          endcase
          if (beat_reg == last_reg)
          begin
            st_next  = EMBI_ST_IDLE;
            rsp_next = 1'b1;
          end
          else
          begin
            beat_next = beat_reg + 2'h1;
            blk_next  = `EMBI_RDY_BLANK;
          end
        end
      end
      EMBI_ST_HOLD:
      begin
        if (!hold_act)
          st_next = EMBI_ST_IDLE;
      end
      default:
        st_next = EMBI_ST_IDLE;
    endcase

    // pin image for the cycle to come
    float_bus = (st_next == EMBI_ST_HOLD) | shz_now;
    case (ow_next)
      EMBI_W8:  lane = off_next + beat_next;
      EMBI_W16: lane = {off_next[1] ^ beat_next[0], off_next[0]};
      default:  lane = off_next;
    endcase
    case (ow_next)
      EMBI_W8:  be = {lane[1], lane[0], 1'b1, 1'b0};
      EMBI_W16: be = {lane[1], 1'b1, (sz_next == EMBI_SZ_BYTE) ? {~lane[0], lane[0]} : 2'h0};
      default:
      begin
        case (sz_next)
          EMBI_SZ_BYTE: be = ~(`EMBI_BYTE_ONE << lane);
          EMBI_SZ_HALF: be = lane[1] ? `EMBI_BE_HI_HALF : `EMBI_BE_LO_HALF;
          default:      be = `EMBI_BE_WORD;
        endcase
      end
    endcase
    case (ow_next)
      EMBI_W8:  dout_next = {24'h000000, wd_next[{lane, 3'h0} +: 8]};
      EMBI_W16: dout_next = {16'h0000, wd_next[{lane[1], 4'h0} +: 16]};
      default:  dout_next = wd_next;
    endcase

    addr_next = oa_next;
    rw_next   = (st_next == EMBI_ST_ACCESS) ? ~wr_next : 1'b1;
    aoe_next  = ~float_bus;
    rwoe_next = ~float_bus;
    doe_next  = ~float_bus & (st_next == EMBI_ST_ACCESS) & wr_next;
    soe_next  = ~float_bus;
    io_next   = ~((st_next == EMBI_ST_ACCESS) & (sp_next == EMBI_SP_IO));
    b0_next   = ((st_next == EMBI_ST_ACCESS) && (sp_next == EMBI_SP_BANK0)) ? be : `EMBI_BE_IDLE;
    b1_next   = ((st_next == EMBI_ST_ACCESS) && (sp_next == EMBI_SP_BANK1)) ? be : `EMBI_BE_IDLE;
    ack_next  = ~(st_next == EMBI_ST_HOLD);
    rdy_next  = (st_next == EMBI_ST_IDLE) & ~hold_act;

    if (sys_rst_i)
    begin
      st_next   = EMBI_ST_IDLE;
      w0_next   = strap_now ? EMBI_W16 : EMBI_W32;
      w1_next   = strap_now ? EMBI_W16 : EMBI_W32;
      ign_next  = 1'b0;
      wr_next   = 1'b0;
      sp_next   = EMBI_SP_BANK0;
      sz_next   = EMBI_SZ_WORD;
      ow_next   = EMBI_W32;
      oa_next   = `EMBI_ADDR_RST;
      off_next  = 2'h0;
      beat_next = 2'h0;
      last_next = 2'h0;
      blk_next  = 3'h0;
      wd_next   = `EMBI_DATA_RST;
      rd_next   = `EMBI_DATA_RST;
      rdy_next  = 1'b0;
      rsp_next  = 1'b0;
      addr_next = `EMBI_ADDR_RST;
      dout_next = `EMBI_DATA_RST;
      aoe_next  = 1'b0;
      doe_next  = 1'b0;
      rwoe_next = 1'b0;
      rw_next   = 1'b1;
      io_next   = 1'b1;
      b0_next   = `EMBI_BE_IDLE;
      b1_next   = `EMBI_BE_IDLE;
      soe_next  = ~shz_now;
      ack_next  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_i)
  begin
    st_reg   <= st_next;
    w0_reg   <= w0_next;
    w1_reg   <= w1_next;
    ign_reg  <= ign_next;
    wr_reg   <= wr_next;
    sp_reg   <= sp_next;
    sz_reg   <= sz_next;
    ow_reg   <= ow_next;
    oa_reg   <= oa_next;
    off_reg  <= off_next;
    beat_reg <= beat_next;
    last_reg <= last_next;
    blk_reg  <= blk_next;
    wd_reg   <= wd_next;
    rd_reg   <= rd_next;
    rdy_reg  <= rdy_next;
    rsp_reg  <= rsp_next;
    addr_reg <= addr_next;
    aoe_reg  <= aoe_next;
    dout_reg <= dout_next;
    doe_reg  <= doe_next;
    rw_reg   <= rw_next;
    rwoe_reg <= rwoe_next;
    io_reg   <= io_next;
    b0_reg   <= b0_next;
    b1_reg   <= b1_next;
    soe_reg  <= soe_next;
    ack_reg  <= ack_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign req_ready_o          = rdy_reg;
  assign rsp_valid_o          = rsp_reg;
  assign rsp_rdata_o          = rd_reg;
  assign ext_addr_lines_o     = addr_reg;
  assign ext_addr_oe_o        = aoe_reg;
  assign ext_data_lines_o     = dout_reg;
  assign ext_data_oe_o        = doe_reg;
  assign ext_rw_o             = rw_reg;
  assign ext_rw_oe_o          = rwoe_reg;
  assign periph_io_strobe_n_o = io_reg;
  assign bank0_be3_addr1_n_o  = b0_reg[3];
  assign bank0_be2_addr2_n_o  = b0_reg[2];
  assign bank0_be1_n_o        = b0_reg[1];
  assign bank0_be0_n_o        = b0_reg[0];
  assign bank1_be3_addr1_n_o  = b1_reg[3];
  assign bank1_be2_addr2_n_o  = b1_reg[2];
  assign bank1_be1_n_o        = b1_reg[1];
  assign bank1_be0_n_o        = b1_reg[0];
  assign strobe_oe_o          = soe_reg;
  assign bus_release_ack_n_o  = ack_reg;

endmodule : embi_bus_ctrl

// file: tb/embi_bus_ctrl_checker.sv
module embi_bus_ctrl_checker
  import embi_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_prog_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic ext_addr_oe_o,
  input wire logic ext_data_oe_o,
  input wire logic ext_rw_o,
  input wire logic ext_rw_oe_o,
  input wire logic periph_io_strobe_n_o,
  input wire logic bank0_be3_addr1_n_o,
  input wire logic bank0_be2_addr2_n_o,
  input wire logic bank0_be1_n_o,
  input wire logic bank0_be0_n_o,
  input wire logic bank1_be3_addr1_n_o,
  input wire logic bank1_be2_addr2_n_o,
  input wire logic bank1_be1_n_o,
  input wire logic bank1_be0_n_o,
  input wire logic strobe_oe_o,
  input wire logic ext_ready_n_i,
  input wire logic hold_req_n_i,
  input wire logic bus_release_ack_n_o,
  input wire logic shutdown_float_input_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rdy_hist_reg;
  logic [5:0] rdy_hist_next;
  wire        idle_pins = &{periph_io_strobe_n_o, bank0_be3_addr1_n_o, bank0_be2_addr2_n_o, bank0_be1_n_o,
                            bank0_be0_n_o, bank1_be3_addr1_n_o, bank1_be2_addr2_n_o, bank1_be1_n_o, bank1_be0_n_o};
  wire        floated = !ext_addr_oe_o && !ext_data_oe_o && !ext_rw_oe_o;

  always_comb rdy_hist_next = {rdy_hist_reg[4:0], ext_ready_n_i};
  always_ff @(posedge clock_i) rdy_hist_reg <= rdy_hist_next;

  ////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_accept;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_sd_long;
    !shutdown_float_input_n_i [*7];
  endsequence

  property p_rw_dir;
    s_accept |=> ext_rw_o == (!req_write_i || req_prog_i);
  endproperty
  property p_rst_float;
    disable iff (1'b0) sys_rst_i |=> floated;
  endproperty
  property p_rst_strobe;
    disable iff (1'b0) (sys_rst_i && shutdown_float_input_n_i) [*7] |-> strobe_oe_o;
  endproperty
  property p_idle_high;
    req_ready_o |-> idle_pins;
  endproperty
  property p_hold_float;
    !bus_release_ack_n_o |-> floated && !strobe_oe_o && !req_ready_o;
  endproperty
  property p_busy_no_grant;
    !idle_pins |-> bus_release_ack_n_o;
  endproperty
  property p_ack_high;
    hold_req_n_i [*7] |-> bus_release_ack_n_o;
  endproperty
  property p_rsp_ready;
    rsp_valid_o |-> !(&rdy_hist_reg) ##1 !rsp_valid_o;
  endproperty
  property p_sd_float;
    s_sd_long |-> floated && !strobe_oe_o;
  endproperty

  a_rw_dir: assert property (p_rw_dir) else $error("rw level wrong");
  a_rst_float: assert property (p_rst_float) else $error("bus driven in reset");
  a_rst_strobe: assert property (p_rst_strobe) else $error("strobes floated by reset");
  a_idle_high: assert property (p_idle_high) else $error("strobe active while idle");
  a_hold_float: assert property (p_hold_float) else $error("bus driven while held");
  a_busy_no_grant: assert property (p_busy_no_grant) else $error("grant during transfer");
  a_ack_high: assert property (p_ack_high) else $error("ack low without hold");
  a_rsp_ready: assert property (p_rsp_ready) else $error("done without ready");
  a_sd_float: assert property (p_sd_float) else $error("bus driven in shutdown");
endmodule : embi_bus_ctrl_checker

bind embi_bus_ctrl embi_bus_ctrl_checker u_chk (.clock_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_prog_i,
  .req_ready_o, .rsp_valid_o, .ext_addr_oe_o, .ext_data_oe_o, .ext_rw_o, .ext_rw_oe_o, .periph_io_strobe_n_o,
  .bank0_be3_addr1_n_o, .bank0_be2_addr2_n_o, .bank0_be1_n_o, .bank0_be0_n_o, .bank1_be3_addr1_n_o,
  .bank1_be2_addr2_n_o, .bank1_be1_n_o, .bank1_be0_n_o, .strobe_oe_o, .ext_ready_n_i, .hold_req_n_i,
  .bus_release_ack_n_o, .shutdown_float_input_n_i);

// file: tb/embi_mem_model.sv
module embi_mem_model (
  input  wire logic        clock_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [8:0]  pins_i,
  input  wire logic        oe_i,
  input  wire logic        rw_i,
  input  wire logic [1:0]  wait_i,
  output logic             ready_n_o,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  last_reg = 9'h1FF;
  logic [1:0]  cnt_reg = 2'h0;
  logic [31:0] idle_reg = 32'h0;
  wire         act = oe_i && pins_i != 9'h1FF;
  wire  [3:0]  p = pins_i[7:4] & pins_i[3:0];

  // read beat drives data, released lines toggle
  assign data_o = (act && rw_i) ? {4{addr_i[3:0], 2'b10, p[3:2]}} : idle_reg;
  initial ready_n_o = 1'b1;
  always @(posedge clock_i)
  begin
    idle_reg <= ~data_o;
    last_reg <= act ? pins_i : 9'h1FF;
    if (!act || pins_i != last_reg)
    begin
      cnt_reg <= 2'h0;
      ready_n_o <= 1'b1;
    end
    else if (cnt_reg == wait_i)
      ready_n_o <= 1'b0;
    else
      cnt_reg <= cnt_reg + 2'h1;
  end
endmodule : embi_mem_model

// file: tb/tb.sv
module tb
  import embi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0, req_prog_i = 0, cfg_wr_i = 0, cfg_bank_i = 0;
  logic cfg_hold_ignore_i = 0, hold_req_n_i = 1, shutdown_float_input_n_i = 1, prog_fetch_width_strap_i = 1;
  logic req_ready_o, rsp_valid_o, ext_addr_oe_o, ext_data_oe_o, ext_rw_o, ext_rw_oe_o, strobe_oe_o;
  logic bus_release_ack_n_o, io_n, ext_ready_n_i;
  embi_space_t req_space_i = EMBI_SP_BANK0;
  embi_size_t  req_size_i = EMBI_SZ_WORD;
  embi_width_t cfg_width_i = EMBI_W32;
  logic [23:0] req_addr_i = 24'h0, ext_addr_lines_o;
  logic [1:0]  req_off_i = 2'h0, mem_wait = 2'h0;
  logic [31:0] req_wdata_i = 32'h0, rsp_rdata_o, ext_data_lines_o, mem_data, seed = 32'h2D70, r;
  logic [3:0]  b0, b1;
  logic [8:0]  q_pin[$], prev = 9'h1FF;
  logic [31:0] q_dat[$];
  logic        q_rw[$];
  int          err_count = 0, checks_done = 0, wid[2], w;
  wire  [8:0]  pins = {io_n, b1, b0};
  wire  [31:0] data_in = ext_data_oe_o ? ext_data_lines_o : mem_data;

  embi_bus_ctrl uut (.clock_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_prog_i, .req_space_i, .req_size_i,
    .req_addr_i, .req_off_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .cfg_wr_i, .cfg_bank_i,
    .cfg_width_i, .cfg_hold_ignore_i, .ext_addr_lines_o, .ext_addr_oe_o, .ext_data_lines_i(data_in),
    .ext_data_lines_o, .ext_data_oe_o, .ext_rw_o, .ext_rw_oe_o, .periph_io_strobe_n_o(io_n),
    .bank0_be3_addr1_n_o(b0[3]), .bank0_be2_addr2_n_o(b0[2]), .bank0_be1_n_o(b0[1]), .bank0_be0_n_o(b0[0]),
    .bank1_be3_addr1_n_o(b1[3]), .bank1_be2_addr2_n_o(b1[2]), .bank1_be1_n_o(b1[1]), .bank1_be0_n_o(b1[0]),
    .strobe_oe_o, .ext_ready_n_i, .hold_req_n_i, .bus_release_ack_n_o, .shutdown_float_input_n_i,
    .prog_fetch_width_strap_i);
  embi_mem_model mem (.clock_i, .addr_i(ext_addr_lines_o), .pins_i(pins), .oe_i(strobe_oe_o), .rw_i(ext_rw_o),
    .wait_i(mem_wait), .ready_n_o(ext_ready_n_i), .data_o(mem_data));

  initial forever #5 clock_i = ~clock_i;

  // beat log: new strobe pattern on the pins
  always @(posedge clock_i)
  begin
    if (strobe_oe_o && pins != 9'h1FF && pins != prev)
    begin
      q_pin.push_back(pins);
      q_rw.push_back(ext_rw_o);
      q_dat.push_back(ext_data_lines_o);
    end
    prev = strobe_oe_o ? pins : 9'h1FF;
  end

  ////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [3:0] pin_f(input int wd, input logic bw, input logic hf, input logic [1:0] e);
    if (wd == 2)
      return bw ? ~(4'h1 << e) : (hf ? (e[1] ? 4'h3 : 4'hC) : 4'h0);
    if (wd == 1)
      return {e[1], 1'b1, bw & ~e[0], bw & e[0]};
    return {e[1], e[0], 2'b10};
  endfunction : pin_f

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, ex);
    end
  endtask : chk

  task automatic wait_sig(ref logic s, input logic v);
    repeat (200)
    begin
      @(posedge clock_i);
      if (s === v)
        return;
    end
    err_count++;
    test_done();
  endtask : wait_sig

  task automatic do_reset(input logic s);
    @(negedge clock_i);
    sys_rst_i = 1;
    prog_fetch_width_strap_i = s;
    repeat (8) @(negedge clock_i);
    sys_rst_i = 0;
    wid[0] = s ? 1 : 2;
    wid[1] = wid[0];
  endtask : do_reset

  task automatic cfg(input logic b, input int wd, input logic ig);
    @(negedge clock_i);
    cfg_wr_i = 1;
    cfg_bank_i = b;
    cfg_width_i = embi_width_t'(wd);
    cfg_hold_ignore_i = ig;
    @(negedge clock_i);
    cfg_wr_i = 0;
    wid[b] = wd;
  endtask : cfg

  task automatic xfer(input int sp, input logic wr, input logic bw, input logic [1:0] off, input logic pg,
                      input logic hm);
    int wd, nb, st, n, L;
    logic [1:0] e;
    logic [3:0] p;
    logic [31:0] ex;
    logic hf;
    wr = wr & !pg;
    bw = bw & wr;
    // spare offset bit of a word write asks for a halfword
    hf = wr & !bw & off[0];
    off = bw ? off : (hf ? {off[1], 1'b0} : 2'h0);
    wd = (sp == 2) ? 2 : wid[sp];
    st = (wd == 1) ? 2 : 1;
    nb = (bw || wd == 2 || (hf && wd == 1)) ? 1 : ((wd == 1 || hf) ? 2 : 4);
    @(negedge clock_i);
    req_valid_i = 1;
    req_write_i = wr;
    req_prog_i = pg;
    req_space_i = embi_space_t'(sp);
    req_size_i = bw ? EMBI_SZ_BYTE : (hf ? EMBI_SZ_HALF : EMBI_SZ_WORD);
    req_addr_i = 24'(xs());
    req_off_i = off;
    req_wdata_i = xs();
    mem_wait = 2'(xs());
    q_pin.delete();
    q_rw.delete();
    q_dat.delete();
    wait_sig(req_ready_o, 1);
    @(negedge clock_i);
    req_valid_i = 0;
    if (hm)
      hold_req_n_i = 0;
    wait_sig(rsp_valid_o, 1);
    chk(q_pin.size(), nb);
    for (n = 0; n < nb; n++)
    begin
      e = 2'(off + n * st);
      p = pin_f(wd, bw, hf, e);
      chk(q_pin[n], sp == 2 ? 9'h0FF : sp == 1 ? {1'b1, p, 4'hF} : {1'b1, 4'hF, p});
      chk(q_rw[n], !wr);
      if (wr && wd == 0)
        chk(q_dat[n][7:0], req_wdata_i[8*e +: 8]);
      if (wr && wd == 1)
        chk(q_dat[n][15:0], req_wdata_i[16*e[1] +: 16]);
      if (wr && wd == 2)
        chk(q_dat[n], req_wdata_i);
    end
    if (!wr)
    begin
      for (L = 0; L < 4; L++)
      begin
        n = (wd == 2) ? 0 : (wd == 1 ? L / 2 : L);
        p = (sp == 2) ? 4'hF : pin_f(wd, 1'b0, 1'b0, 2'(n * st));
        ex[8*L +: 8] = {req_addr_i[3:0], 2'b10, p[3:2]};
      end
      chk(rsp_rdata_o, ex);
    end
  endtask : xfer

  ////////////////////////////////////////////////
  initial
  begin
    do_reset(1);
    xfer(0, 0, 0, 0, 1, 0);
    do_reset(0);
    xfer(1, 0, 0, 0, 1, 0);
    for (w = 0; w < 3; w++)
    begin
      cfg(0, w, 0);
      cfg(1, 2 - w, 0);
      repeat (8)
      begin
        r = xs();
        xfer(r % 3, r[3], r[4], r[6:5], 0, 0);
      end
    end
    xfer(0, 1, 0, 0, 0, 1);
    wait_sig(bus_release_ack_n_o, 0);
    repeat (8)
    begin
      @(posedge clock_i);
      chk(req_ready_o, 0);
    end
    cfg(0, wid[0], 1);
    wait_sig(bus_release_ack_n_o, 1);
    xfer(1, 0, 0, 0, 0, 0);
    cfg(0, wid[0], 0);
    wait_sig(bus_release_ack_n_o, 0);
    @(negedge clock_i);
    hold_req_n_i = 1;
    wait_sig(bus_release_ack_n_o, 1);
    @(negedge clock_i);
    shutdown_float_input_n_i = 0;
    repeat (8) @(negedge clock_i);
    chk({strobe_oe_o, ext_addr_oe_o, ext_rw_oe_o}, 0);
    shutdown_float_input_n_i = 1;
    repeat (6) @(negedge clock_i);
    chk(strobe_oe_o, 1);
    test_done();
  end
endmodule : tb
